// *** logic/timer_channel.sv ***
// timer_channel: one capture/compare/pwm channel with its pin
// assumes counter, step and period pulses from the parent timer on pclk
module timer_channel
  import timer_pkg::*;
(
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        sc_we,
  input  wire logic                        sc_re,
  input  wire logic                        v_we,
  input  wire logic [7:0]                  wdata_sc,
  input  wire logic [timer_pkg::CNT_W-1:0] wdata_v,
  input  wire logic [timer_pkg::CNT_W-1:0] cnt,
  input  wire logic                        step,
  input  wire logic                        period,
  input  wire logic                        center,
  input  wire logic                        pin_in,
  output timer_pkg::chan_sc_type           sc_rd,
  output logic      [timer_pkg::CNT_W-1:0] v_rd,
  output logic                             pin_out,
  output logic                             pin_oe,
  output logic                             pin_owned,
  output logic                             irq
);
  chan_sc_type      sc_q;
  logic [CNT_W-1:0] val_q, act_q, cmp;
  logic s1_q, s2_q, s3_q, arm_q;
  logic is_ic, is_oc, is_pwm, hit, cap, ev;

  assign is_ic  = !center && sc_q.mode == MODE_IC;
  assign is_oc  = !center && sc_q.mode == MODE_OC;
  assign is_pwm = center || sc_q.mode[1];
  assign cmp    = is_pwm ? act_q : val_q;
  assign hit    = step && cnt == cmp;
  assign cap    = is_ic && ((sc_q.edge_level_select[0] && s2_q && !s3_q)
                  || (sc_q.edge_level_select[1] && !s2_q && s3_q));
  assign ev     = is_ic ? cap : hit;
  assign sc_rd  = sc_q;
  assign v_rd   = val_q;

  // pin synchroniser, edge history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // control, flag with read-then-write-zero clear; set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sc_q  <= SC_RESET;
      arm_q <= 1'b0;
    end else begin
      if (sc_we) begin
        sc_q.ie                <= wdata_sc[6];
        sc_q.mode              <= wdata_sc[5:4];
        sc_q.edge_level_select <= wdata_sc[3:2];
      end
      if (ev) begin
        sc_q.flag <= 1'b1;
        arm_q     <= 1'b0;
      end else if (sc_we && arm_q && !wdata_sc[7]) begin
        sc_q.flag <= 1'b0;
        arm_q     <= 1'b0;
      end else if (sc_re && sc_q.flag) begin
        arm_q <= 1'b1;
      end
    end
  end

  // value register; pwm duty is buffered to the period start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      val_q <= CNT_ZERO;
      act_q <= CNT_ZERO;
    end else begin
      if (cap) begin
        val_q <= cnt;
      end else if (v_we) begin
        val_q <= wdata_v;
      end
      if (!is_pwm || period) begin
        act_q <= val_q;
      end
    end
  end

  // output level and pin ownership
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out   <= 1'b0;
      pin_oe    <= 1'b0;
      pin_owned <= 1'b0;
      irq       <= 1'b0;
    end else begin
      pin_owned <= sc_q.edge_level_select != ELS_NONE;
      pin_oe    <= sc_q.edge_level_select != ELS_NONE && !is_ic;
      irq       <= sc_q.flag && sc_q.ie;
      if (center) begin
        pin_out <= (cnt < act_q) ^ sc_q.edge_level_select[0];
      end else if (is_oc && hit) begin
        case (sc_q.edge_level_select)
          ELS_RISE: pin_out <= !pin_out;
          ELS_FALL: pin_out <= 1'b0;
          ELS_ANY:  pin_out <= 1'b1;
          default:  pin_out <= pin_out;
        endcase
      end else if (is_pwm && hit) begin
        pin_out <= sc_q.edge_level_select[0];
      end else if (is_pwm && period) begin
        pin_out <= !sc_q.edge_level_select[0];
      end
    end
  end

  capture_value_a: assert property (@(posedge pclk) disable iff (!presetn)
    cap |=> val_q == $past(cnt))
    else $error("capture did not store the counter");

  pin_release_a: assert property (@(posedge pclk) disable iff (!presetn)
    sc_q.edge_level_select == ELS_NONE |=> !pin_oe && !pin_owned)
    else $error("pin still held with edge select cleared");

endmodule : timer_channel

// *** logic/timer_pkg.sv ***
// timer_pkg: shared constants and types of the capture/compare/pwm timer
// assumes a 32-bit apb register bus clocked by pclk
package timer_pkg;

  localparam int CNT_W = 16;
  localparam int PRE_W = 7;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  typedef enum logic [1:0] {
    CLK_OFF   = 2'b00,
    CLK_BUS   = 2'b01,
    CLK_FIXED = 2'b10,
    CLK_EXT   = 2'b11
  } clk_src_type;

  typedef enum logic {
    DIR_UP   = 1'b0,
    DIR_DOWN = 1'b1
  } dir_type;

  typedef struct packed {
    logic        overflow_flag;
    logic        overflow_ie;
    logic        center_mode_select;
    clk_src_type clock_source_select;
    logic [2:0]  prescale;
  } timer_sc_type;

  typedef struct packed {
    logic       flag;
    logic       ie;
    logic [1:0] mode;
    logic [1:0] edge_level_select;
    logic [1:0] unused;
  } chan_sc_type;

  localparam logic [ADDR_W-1:0] OFF_SC     = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CNT_HI = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CNT_LO = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_MOD    = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_CH     = 8'h10;
  localparam int CH_SHIFT = 3;
  localparam int CH_VAL_BIT = 2;

  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_ALL  = 16'hFFFF;
  localparam logic [PRE_W-1:0] PRE_ALL  = 7'h7F;
  localparam logic [PRE_W-1:0] PRE_ZERO = 7'h00;
  localparam logic [7:0] SC_RESET = 8'h00;
  localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;

  localparam logic [1:0] MODE_IC  = 2'b00;
  localparam logic [1:0] MODE_OC  = 2'b01;
  localparam logic [1:0] ELS_NONE = 2'b00;
  localparam logic [1:0] ELS_RISE = 2'b01;
  localparam logic [1:0] ELS_FALL = 2'b10;
  localparam logic [1:0] ELS_ANY  = 2'b11;

endpackage : timer_pkg

// *** logic/timer_top.sv ***
// timer_top: 16-bit capture/compare/pwm timer behind an apb slave
// assumes apb master on pclk; pins arrive asynchronous to pclk
//
// Our own choices: register access over APB and the placing of the registers.
module timer_top
  import timer_pkg::*;
#(
  parameter int NUM_CH = 2
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [timer_pkg::ADDR_W-1:0] paddr,
  input  wire logic [timer_pkg::DATA_W-1:0] pwdata,
  output logic      [timer_pkg::DATA_W-1:0] prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        fixed_system_clock,
  input  wire logic                        external_count_clock_pin,
  input  wire logic [NUM_CH-1:0]           timer_channel_pin_in,
  output logic      [NUM_CH-1:0]           timer_channel_pin_out,
  output logic      [NUM_CH-1:0]           timer_channel_pin_oe,
  output logic      [NUM_CH-1:0]           timer_channel_pin_owned,
  output logic                             overflow_irq,
  output logic      [NUM_CH-1:0]           channel_irq
);
  import timer_pkg::*;

  timer_sc_type     sc_q;
  dir_type          dir_q;
  logic [CNT_W-1:0] cnt_q, modulo_value_q, lat_q, lim;
  logic [PRE_W-1:0] pre_q, pre_mask;
  logic             tof_arm_q, lat_on_q, lat_hi_q;
  logic             ext_s1_q, ext_s2_q, ext_s3_q;
  logic             setup, acc, rd_ev, wr_ev;
  logic             sel_sc, sel_hi, sel_lo, sel_mod, sel_ch, hit_map;
  logic             src_tick, step, ovf, free, cnt_wr, at_lim;
  logic [ADDR_W-1:0] ch_off;
  logic [ADDR_W-CH_SHIFT-1:0] ch_idx;
  logic [DATA_W-1:0] rd_d;
  logic [NUM_CH-1:0] ch_sc_we, ch_sc_re, ch_v_we;
  chan_sc_type      ch_sc [NUM_CH];
  logic [CNT_W-1:0] ch_v  [NUM_CH];

  // apb phases
  assign setup = psel && !penable;
  assign acc   = psel && penable && pready;
  assign rd_ev = setup && !pwrite;
  assign wr_ev = acc && pwrite;

  // address decode
  assign ch_off  = paddr - OFF_CH;
  assign ch_idx  = ch_off[ADDR_W-1:CH_SHIFT];
  assign sel_sc  = paddr == OFF_SC;
  assign sel_hi  = paddr == OFF_CNT_HI;
  assign sel_lo  = paddr == OFF_CNT_LO;
  assign sel_mod = paddr == OFF_MOD;
  assign sel_ch  = paddr >= OFF_CH && paddr[1:0] == 2'b00
                   && 32'(ch_idx) < NUM_CH;
  assign hit_map = sel_sc || sel_hi || sel_lo || sel_mod || sel_ch;
  assign cnt_wr  = wr_ev && (sel_hi || sel_lo);

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      ch_sc_we[i] = wr_ev && sel_ch && 32'(ch_idx) == i
                    && !ch_off[CH_VAL_BIT];
      ch_v_we[i]  = wr_ev && sel_ch && 32'(ch_idx) == i
                    && ch_off[CH_VAL_BIT];
      ch_sc_re[i] = rd_ev && sel_ch && 32'(ch_idx) == i
                    && !ch_off[CH_VAL_BIT];
    end
  end

  // read mux; the counter bytes honour the coherency latch
  always_comb begin
    rd_d = RD_ZERO;
    if (sel_sc) begin
      rd_d = DATA_W'(sc_q);
    end else if (sel_hi) begin
      rd_d = DATA_W'(lat_on_q ? lat_q[15:8] : cnt_q[15:8]);
    end else if (sel_lo) begin
      rd_d = DATA_W'(lat_on_q ? lat_q[7:0] : cnt_q[7:0]);
    end else if (sel_mod) begin
      rd_d = DATA_W'(modulo_value_q);
    end else if (sel_ch) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (32'(ch_idx) == i) begin
          rd_d = ch_off[CH_VAL_BIT] ? DATA_W'(ch_v[i])
                                    : DATA_W'(ch_sc[i]);
        end
      end
    end
  end

  // apb answer: one access cycle after each setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= RD_ZERO;
    end else begin
      pready <= setup;
      if (setup) begin
        pslverr <= !hit_map;
        prdata  <= pwrite ? RD_ZERO : rd_d;
      end
    end
  end

  // status/control and modulo registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sc_q           <= SC_RESET;
      modulo_value_q <= CNT_ZERO;
      tof_arm_q      <= 1'b0;
    end else begin
      if (wr_ev && sel_sc) begin
        sc_q.overflow_ie         <= pwdata[6];
        sc_q.center_mode_select  <= pwdata[5];
        sc_q.clock_source_select <= clk_src_type'(pwdata[4:3]);
        sc_q.prescale            <= pwdata[2:0];
      end
      if (wr_ev && sel_mod) begin
        modulo_value_q <= pwdata[CNT_W-1:0];
      end
      if (ovf) begin
        sc_q.overflow_flag <= 1'b1;
        tof_arm_q          <= 1'b0;
      end else if (wr_ev && sel_sc && tof_arm_q && !pwdata[7]) begin
        sc_q.overflow_flag <= 1'b0;
        tof_arm_q          <= 1'b0;
      end else if (rd_ev && sel_sc && sc_q.overflow_flag) begin
        tof_arm_q <= 1'b1;
      end
    end
  end

  // counter byte coherency latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_on_q <= 1'b0;
      lat_hi_q <= 1'b0;
      lat_q    <= CNT_ZERO;
    end else if (cnt_wr || (wr_ev && sel_sc)) begin
      lat_on_q <= 1'b0;
    end else if (rd_ev && (sel_hi || sel_lo)) begin
      if (!lat_on_q) begin
        lat_on_q <= 1'b1;
        lat_hi_q <= sel_hi;
        lat_q    <= cnt_q;
      end else if (lat_hi_q != sel_hi) begin
        lat_on_q <= 1'b0;
      end
    end
  end

  // external clock: two-stage sync then rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= external_count_clock_pin;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  // clock source selection
  always_comb begin
    case (sc_q.clock_source_select)
      CLK_BUS:   src_tick = 1'b1;
      CLK_FIXED: src_tick = fixed_system_clock;
      CLK_EXT:   src_tick = ext_s2_q && !ext_s3_q;
      default:   src_tick = 1'b0;
    endcase
  end

  // prescaler: step when the low ps bits are all ones
  assign pre_mask = ~(PRE_ALL << sc_q.prescale);
  assign step     = src_tick && (pre_q & pre_mask) == pre_mask;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= PRE_ZERO;
    end else if (cnt_wr || sc_q.clock_source_select == CLK_OFF) begin
      pre_q <= PRE_ZERO;
    end else if (src_tick) begin
      pre_q <= pre_q + 7'd1;
    end
  end

  // counting limit and overflow event
  assign free   = modulo_value_q == CNT_ZERO
                  || modulo_value_q == CNT_ALL;
  assign lim    = free ? CNT_ALL : modulo_value_q;
  assign at_lim = cnt_q >= lim;
  assign ovf    = step && !cnt_wr
                  && (sc_q.center_mode_select ? dir_q == DIR_UP && at_lim
                                              : cnt_q == lim);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= CNT_ZERO;
      dir_q <= DIR_UP;
    end else if (cnt_wr) begin
      cnt_q <= CNT_ZERO;
      dir_q <= DIR_UP;
    end else if (step) begin
      if (!sc_q.center_mode_select) begin
        dir_q <= DIR_UP;
        cnt_q <= cnt_q == lim ? CNT_ZERO : cnt_q + CNT_ONE;
      end else if (dir_q == DIR_UP) begin
        if (at_lim) begin
          dir_q <= DIR_DOWN;
          cnt_q <= cnt_q - CNT_ONE;
        end else begin
          cnt_q <= cnt_q + CNT_ONE;
        end
      end else if (cnt_q == CNT_ZERO) begin
        dir_q <= DIR_UP;
        cnt_q <= CNT_ONE;
      end else begin
        cnt_q <= cnt_q - CNT_ONE;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_irq <= 1'b0;
    end else begin
      overflow_irq <= sc_q.overflow_flag && sc_q.overflow_ie;
    end
  end

  // replicated channels
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    timer_channel u_ch (
      .pclk      (pclk),
      .presetn   (presetn),
      .sc_we     (ch_sc_we[g]),
      .sc_re     (ch_sc_re[g]),
      .v_we      (ch_v_we[g]),
      .wdata_sc  (pwdata[7:0]),
      .wdata_v   (pwdata[CNT_W-1:0]),
      .cnt       (cnt_q),
      .step      (step),
      .period    (ovf),
      .center    (sc_q.center_mode_select),
      .pin_in    (timer_channel_pin_in[g]),
      .sc_rd     (ch_sc[g]),
      .v_rd      (ch_v[g]),
      .pin_out   (timer_channel_pin_out[g]),
      .pin_oe    (timer_channel_pin_oe[g]),
      .pin_owned (timer_channel_pin_owned[g]),
      .irq       (channel_irq[g])
    );
  end

  counter_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    cnt_wr |=> cnt_q == CNT_ZERO && pre_q == PRE_ZERO)
    else $error("counter write did not clear the counter");

  read_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_ev && !step && !cnt_wr |=> $stable(cnt_q))
    else $error("counter read disturbed the count");

  free_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
    step && !cnt_wr && !sc_q.center_mode_select && free
    && cnt_q == CNT_ALL |=> cnt_q == CNT_ZERO && sc_q.overflow_flag)
    else $error("free-running counter did not wrap");

  modulo_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
    step && !cnt_wr && !sc_q.center_mode_select && !free
    && cnt_q == modulo_value_q |=> cnt_q == CNT_ZERO)
    else $error("modulo counter did not return to zero");

  clock_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    sc_q.clock_source_select == CLK_OFF && !cnt_wr
    |=> $stable(cnt_q))
    else $error("counter moved with no clock selected");

  prescale_a: assert property (@(posedge pclk) disable iff (!presetn)
    sc_q.clock_source_select == CLK_BUS && sc_q.prescale == 3'd7
    && !cnt_wr && step |=> !step [*7])
    else $error("divide by 128 stepped too soon");

  flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    ovf |=> sc_q.overflow_flag && !tof_arm_q)
    else $error("overflow did not set the flag");

  center_turn_a: assert property (@(posedge pclk) disable iff (!presetn)
    step && !cnt_wr && sc_q.center_mode_select && dir_q == DIR_UP
    && cnt_q == lim |=> cnt_q == $past(lim) - CNT_ONE
    && dir_q == DIR_DOWN)
    else $error("center mode did not turn down at modulo");

  latch_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd_ev && sel_hi && !lat_on_q && !cnt_wr
    |=> lat_on_q && lat_q == $past(cnt_q))
    else $error("high byte read did not latch the counter");

  ext_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
    sc_q.clock_source_select == CLK_EXT && src_tick |=> !src_tick)
    else $error("one external edge gave two counts");

  overflow_seen_c: cover property (@(posedge pclk) disable iff (!presetn)
    ovf ##2 overflow_irq);

  flag_cleared_c: cover property (@(posedge pclk) disable iff (!presetn)
    sc_q.overflow_flag ##1 !sc_q.overflow_flag);

  center_down_c: cover property (@(posedge pclk) disable iff (!presetn)
    dir_q == DIR_DOWN ##1 dir_q == DIR_UP);

  ext_count_c: cover property (@(posedge pclk) disable iff (!presetn)
    sc_q.clock_source_select == CLK_EXT && step);

endmodule : timer_top

// *** sim/pin_model.sv ***
// pin_model: far side of the timer pins, external clock and channel inputs
// assumes the bench calls burst and set_ch from its own process
module pin_model #(
  parameter int NUM_CH = 2
) (
  output logic              ext_pin,
  output logic [NUM_CH-1:0] ch_pin
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    ext_pin = 1'b0;
    ch_pin = '0;
  end

  // clock stands low between bursts; 40 ns period is a quarter of pclk rate
  task automatic burst(input int n);
    #3;
    repeat (n) begin
      #20 ext_pin = 1'b1;
      #20 ext_pin = 1'b0;
    end
  endtask : burst

  // pin edges land off the pclk grid
  task automatic set_ch(input int i, input logic v);
    #3 ch_pin[i] = v;
  endtask : set_ch
endmodule : pin_model

// *** sim/tb_timer_top.sv ***
// tb_timer_top: self-checking bench for the apb timer
// assumes timer_top, timer_pkg and pin_model are compiled first
module tb_timer_top;
  timeunit 1ns;
  timeprecision 100ps;
  import timer_pkg::*;
  localparam int LIMIT = 20000;
  logic              pclk, presetn, psel, penable, pwrite, fsc;
  logic              pready, pslverr, ovf_irq, ext_pin, err;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic [1:0]        ch_in, ch_out, ch_oe, ch_own, ch_irq;
  logic [1:0]        els_t [3] = '{2'b11, 2'b10, 2'b01};
  logic              exp_t [3] = '{1'b1, 1'b0, 1'b1};
  int                n_mismatch, samples_checked, cycles;

  timer_top #(.NUM_CH(2)) timer_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fixed_system_clock(fsc),
    .external_count_clock_pin(ext_pin), .timer_channel_pin_in(ch_in),
    .timer_channel_pin_out(ch_out), .timer_channel_pin_oe(ch_oe),
    .timer_channel_pin_owned(ch_own), .overflow_irq(ovf_irq),
    .channel_irq(ch_irq)
  );
  pin_model #(.NUM_CH(2)) pin_model_inst (.ext_pin(ext_pin), .ch_pin(ch_in));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_mismatch++;
      conclude();
    end
  end

  task conclude;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  task chk(input string what, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task rchk(input logic [7:0] a, input logic [31:0] e, input string what);
    xfer(1'b0, a, 32'h0000_0000);
    chk(what, rd, e);
  endtask : rchk

  task cnt_chk(input logic [15:0] e);
    logic [7:0] hi;
    xfer(1'b0, OFF_CNT_HI, 32'h0000_0000);
    hi = rd[7:0];
    xfer(1'b0, OFF_CNT_LO, 32'h0000_0000);
    chk("counter", {16'h0000, hi, rd[7:0]}, {16'h0000, e});
  endtask : cnt_chk

  task tick(input int n);
    repeat (n) @(posedge pclk) fsc <= 1'b1;
    @(posedge pclk) fsc <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : tick

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    fsc = 1'b0;
    n_mismatch = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("owned", ch_own, 2'b00);
    rchk(OFF_SC, 32'h0000_0000, "sc reset");
    rchk(OFF_MOD, 32'h0000_0000, "mod reset");
    xfer(1'b0, 8'hFC, 32'h0000_0000);
    chk("slverr", err, 1'b1);
    chk("unmapped", rd, 32'h0000_0000);
    for (int k = 0; k < 8; k++) begin
      wr(OFF_SC, 32'h0000_0010 | k);
      wr(OFF_CNT_LO, 32'h0000_00AA);
      tick(3 << k);
      cnt_chk(16'h0003);
    end
    wr(OFF_SC, 32'h0000_0010);
    rchk(OFF_CNT_LO, 32'h0000_0003, "cnt lo");
    tick(256);
    rchk(OFF_CNT_HI, 32'h0000_0000, "cnt hi latched");
    cnt_chk(16'h0103);
    wr(OFF_MOD, 32'h0000_0005);
    wr(OFF_SC, 32'h0000_0050);
    wr(OFF_CNT_HI, 32'h0000_0055);
    tick(6);
    chk("ovf irq", ovf_irq, 1'b1);
    rchk(OFF_SC, 32'h0000_00D0, "sc ovf");
    wr(OFF_SC, 32'h0000_00D0);
    rchk(OFF_SC, 32'h0000_00D0, "sc w1");
    wr(OFF_SC, 32'h0000_0050);
    rchk(OFF_SC, 32'h0000_0050, "sc clr");
    chk("ovf irq low", ovf_irq, 1'b0);
    tick(2);
    cnt_chk(16'h0002);
    wr(OFF_MOD, 32'h0000_0003);
    wr(OFF_SC, 32'h0000_0030);
    wr(OFF_CNT_LO, 32'h0000_0000);
    tick(3);
    cnt_chk(16'h0003);
    rchk(OFF_SC, 32'h0000_0030, "center top");
    tick(1);
    cnt_chk(16'h0002);
    rchk(OFF_SC, 32'h0000_00B0, "center ovf");
    wr(OFF_SC, 32'h0000_0018);
    wr(OFF_MOD, 32'h0000_0000);
    wr(OFF_CNT_LO, 32'h0000_0000);
    pin_model_inst.burst(5);
    repeat (8) @(posedge pclk);
    wr(OFF_SC, 32'h0000_0010);
    cnt_chk(16'h0005);
    wr(8'h10, 32'h0000_0044);
    repeat (2) @(posedge pclk);
    chk("own0", ch_own[0], 1'b1);
    chk("oe0", ch_oe[0], 1'b0);
    pin_model_inst.set_ch(0, 1'b1);
    repeat (8) @(posedge pclk);
    rchk(8'h14, 32'h0000_0005, "capture rise");
    rchk(8'h10, 32'h0000_00C4, "ch0 flag");
    chk("ch irq", ch_irq[0], 1'b1);
    wr(8'h10, 32'h0000_0048);
    tick(2);
    pin_model_inst.set_ch(0, 1'b0);
    repeat (8) @(posedge pclk);
    rchk(8'h14, 32'h0000_0007, "capture fall");
    wr(8'h10, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    chk("own0 off", ch_own[0], 1'b0);
    wr(8'h1C, 32'h0000_0004);
    for (int i = 0; i < 3; i++) begin
      wr(8'h18, 32'h0000_0010 | (els_t[i] << 2));
      repeat (2) @(posedge pclk);
      chk("oe1", ch_oe[1], 1'b1);
      wr(OFF_CNT_LO, 32'h0000_0000);
      tick(4);
      chk("oc before", ch_out[1], !exp_t[i]);
      tick(1);
      chk("oc match", ch_out[1], exp_t[i]);
    end
    wr(OFF_MOD, 32'h0000_0007);
    wr(8'h1C, 32'h0000_0003);
    wr(8'h18, 32'h0000_0028);
    wr(8'h1C, 32'h0000_0006);
    wr(OFF_CNT_LO, 32'h0000_0000);
    tick(4);
    chk("pwm match", ch_out[1], 1'b0);
    tick(4);
    chk("pwm period", ch_out[1], 1'b1);
    tick(6);
    chk("pwm buffered", ch_out[1], 1'b1);
    tick(1);
    chk("pwm new duty", ch_out[1], 1'b0);
    conclude();
  end
endmodule : tb_timer_top
